/* rtl/uam_auto_address_match.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "uam_defines.svh"

module uam_auto_address_match (
    // Clock, reset and enable.
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       ce,
    // Register port.
    input  wire uam_pkg::uam_reg_req_type   regReq,
    output logic [`UAM_DATA_W-1:0]          rdData,
    // Frames from the receive shifter.
    input  wire uam_pkg::uam_rx_frame_type  rxFrame,
    input  wire logic                       rxComplete,
    // Control levels towards the rest of the port.
    output logic [1:0]                      serialMode,
    output logic                            receiveEnable,
    output logic                            txNinthBit,
    output logic                            txDoneFlag,
    // Receive status.
    output logic                            rxDoneFlag,
    output logic                            rxNinthBit,
    output logic                            frameAccepted,
    // Interrupt.
    output logic                            irq
);

    logic [`UAM_DATA_W-1:0] ctrl_reg;
    logic [`UAM_DATA_W-1:0] ctrl_next;
    logic [`UAM_DATA_W-1:0] slaveAddr_reg;
    logic [`UAM_DATA_W-1:0] slaveMask_reg;
    logic [`UAM_DATA_W-1:0] rxData_reg;
    logic [`UAM_IRQ_W-1:0]  irqStatus_reg;
    logic [`UAM_IRQ_W-1:0]  irqStatus_next;
    logic [`UAM_IRQ_W-1:0]  irqMask_reg;
    logic [`UAM_IRQ_W-1:0]  irqMask_next;
    logic [`UAM_INFO_W-1:0] matchInfo_reg;
    logic [`UAM_DATA_W-1:0] rdData_reg;
    logic                   irq_reg;
    logic                   accept_reg;

    logic [1:0]             mode;
    logic                   multiprocOn;
    logic                   nineBitMode;
    logic                   givenHit;
    logic                   broadcastHit;
    logic                   isAddress;
    logic                   acceptNow;
    logic                   addrHitNow;
    logic                   addrMissNow;
    logic                   dataDropNow;
    logic                   overrunNow;
    logic [`UAM_IRQ_W-1:0]  irqEvents;
    logic [`UAM_IRQ_W-1:0]  irqClear;

    logic                   wrCtrl;
    logic                   wrAddr;
    logic                   wrMask;
    logic                   wrStatus;
    logic                   wrIrqMask;

    // Register write decode.
    assign wrCtrl    = regReq.wrStrobe && (regReq.addr == `UAM_OFS_SERIAL_CTRL);
    assign wrAddr    = regReq.wrStrobe && (regReq.addr == `UAM_OFS_SLAVE_ADDR);
    assign wrMask    = regReq.wrStrobe && (regReq.addr == `UAM_OFS_SLAVE_MASK);
    assign wrStatus  = regReq.wrStrobe && (regReq.addr == `UAM_OFS_IRQ_STATUS);
    assign wrIrqMask = regReq.wrStrobe && (regReq.addr == `UAM_OFS_IRQ_MASK);

    // Control fields.
    assign mode        = {ctrl_reg[`UAM_CTRL_MODE_HI], ctrl_reg[`UAM_CTRL_MODE_LO]};
    assign multiprocOn = ctrl_reg[`UAM_CTRL_MULTIPROC];
    assign nineBitMode = (mode == `UAM_MODE2) || (mode == `UAM_MODE3);

    assign isAddress = rxFrame.ninth;

    uam_addr_match #(
        .WIDTH        (`UAM_DATA_W)
    ) u_match (
        .rxByte       (rxFrame.data),
        .slaveAddr    (slaveAddr_reg),
        .slaveMask    (slaveMask_reg),
        .givenHit     (givenHit),
        .broadcastHit (broadcastHit)
    );

    // Acceptance decision for a completed frame.
    always_comb begin
        acceptNow   = 1'b0;
        addrHitNow  = 1'b0;
        addrMissNow = 1'b0;
        dataDropNow = 1'b0;
        if (rxComplete) begin
            case (mode)
                `UAM_MODE0: begin
                    acceptNow = 1'b1;
                end
                // A set enable in mode 1 only demands a valid stop bit.
                `UAM_MODE1: begin
                    acceptNow = !multiprocOn || rxFrame.stopOk;
                end
                `UAM_MODE2,
                `UAM_MODE3: begin
                    if (!multiprocOn) begin
                        acceptNow = 1'b1;
                    end else if (isAddress) begin
                        acceptNow   = givenHit || broadcastHit;
                        addrHitNow  = givenHit || broadcastHit;
                        addrMissNow = !(givenHit || broadcastHit);
                    end else begin
                        dataDropNow = 1'b1;
                    end
                end
                default: begin
                    acceptNow = 1'b0;
                end
            endcase
        end
    end

    // A new accepted frame while the done flag is still up overwrites the byte.
    assign overrunNow = acceptNow && ctrl_reg[`UAM_CTRL_RX_DONE];

    // Serial control next value: software write first, hardware sets on top.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wrCtrl) begin
            ctrl_next = regReq.wrData;
        end
        if (acceptNow) begin
            ctrl_next[`UAM_CTRL_RX_DONE] = 1'b1;
        end
        if (rxComplete && nineBitMode) begin
            ctrl_next[`UAM_CTRL_RX_NINTH] = rxFrame.ninth;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg <= `UAM_CTRL_RESET;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            slaveAddr_reg <= `UAM_SLAVE_ADDR_RESET;
        end else if (ce && wrAddr) begin
            slaveAddr_reg <= regReq.wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            slaveMask_reg <= `UAM_SLAVE_MASK_RESET;
        end else if (ce && wrMask) begin
            slaveMask_reg <= regReq.wrData;
        end
    end

    // Only accepted frames reach the receive data register, so filtered
    // traffic never disturbs a byte that software has not yet read.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxData_reg <= `UAM_RX_DATA_RESET;
        end else if (ce && acceptNow) begin
            rxData_reg <= rxFrame.data;
        end
    end

    // Last comparison result, kept for software diagnosis.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            matchInfo_reg <= `UAM_INFO_RESET;
        end else if (ce && rxComplete) begin
            matchInfo_reg[`UAM_INFO_GIVEN]     <= givenHit;
            matchInfo_reg[`UAM_INFO_BROADCAST] <= broadcastHit;
            matchInfo_reg[`UAM_INFO_NINTH]     <= rxFrame.ninth;
        end
    end

    // Interrupt events.
    always_comb begin
        irqEvents                   = `UAM_IRQ_RESET;
        irqEvents[`UAM_IRQ_ACCEPT]    = acceptNow;
        irqEvents[`UAM_IRQ_ADDR_HIT]  = addrHitNow;
        irqEvents[`UAM_IRQ_ADDR_MISS] = addrMissNow;
        irqEvents[`UAM_IRQ_DATA_DROP] = dataDropNow;
        irqEvents[`UAM_IRQ_OVERRUN]   = overrunNow;
    end

    // Writing a one clears a status bit; an event in the same cycle wins.
    assign irqClear       = wrStatus ? regReq.wrData[`UAM_IRQ_W-1:0] : `UAM_IRQ_RESET;
    assign irqStatus_next = (irqStatus_reg & ~irqClear) | irqEvents;
    assign irqMask_next   = wrIrqMask ? regReq.wrData[`UAM_IRQ_W-1:0] : irqMask_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqStatus_reg <= `UAM_IRQ_RESET;
        end else if (ce) begin
            irqStatus_reg <= irqStatus_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqMask_reg <= `UAM_IRQ_RESET;
        end else if (ce) begin
            irqMask_reg <= irqMask_next;
        end
    end

    // Built from next values so the output tracks the status register exactly.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |(irqStatus_next & irqMask_next);
        end
    end

    // One-cycle pulse for each frame that got through the filter.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            accept_reg <= 1'b0;
        end else if (ce) begin
            accept_reg <= acceptNow;
        end
    end

    // Read data stand for one cycle after the strobe and read zero otherwise.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdData_reg <= '0;
        end else if (ce) begin
            rdData_reg <= '0;
            if (regReq.rdStrobe) begin
                case (regReq.addr)
                    `UAM_OFS_SERIAL_CTRL: begin
                        rdData_reg <= ctrl_reg;
                    end
                    `UAM_OFS_SLAVE_ADDR: begin
                        rdData_reg <= slaveAddr_reg;
                    end
                    `UAM_OFS_SLAVE_MASK: begin
                        rdData_reg <= slaveMask_reg;
                    end
                    `UAM_OFS_RX_DATA: begin
                        rdData_reg <= rxData_reg;
                    end
                    `UAM_OFS_IRQ_STATUS: begin
                        rdData_reg <= `UAM_DATA_W'(irqStatus_reg);
                    end
                    `UAM_OFS_IRQ_MASK: begin
                        rdData_reg <= `UAM_DATA_W'(irqMask_reg);
                    end
                    `UAM_OFS_MATCH_INFO: begin
                        rdData_reg <= `UAM_DATA_W'(matchInfo_reg);
                    end
                    default: begin
                        rdData_reg <= '0;
                    end
                endcase
            end
        end
    end

    // Outputs, all straight from flip-flops.
    assign rdData        = rdData_reg;
    assign serialMode    = {ctrl_reg[`UAM_CTRL_MODE_HI], ctrl_reg[`UAM_CTRL_MODE_LO]};
    assign receiveEnable = ctrl_reg[`UAM_CTRL_RX_ENABLE];
    assign txNinthBit    = ctrl_reg[`UAM_CTRL_TX_NINTH];
    assign txDoneFlag    = ctrl_reg[`UAM_CTRL_TX_DONE];
    assign rxDoneFlag    = ctrl_reg[`UAM_CTRL_RX_DONE];
    assign rxNinthBit    = ctrl_reg[`UAM_CTRL_RX_NINTH];
    assign frameAccepted = accept_reg;
    assign irq           = irq_reg;

endmodule : uam_auto_address_match

/* rtl/uam_defines.svh */
`ifndef UAM_DEFINES_SVH
`define UAM_DEFINES_SVH

// Register port widths.
`define UAM_ADDR_W             12
`define UAM_DATA_W             8

// Register offsets.
`define UAM_OFS_SERIAL_CTRL    12'h420
`define UAM_OFS_SLAVE_ADDR     12'h428
`define UAM_OFS_SLAVE_MASK     12'h429
`define UAM_OFS_RX_DATA        12'h42c
`define UAM_OFS_IRQ_STATUS     12'h430
`define UAM_OFS_IRQ_MASK       12'h431
`define UAM_OFS_MATCH_INFO     12'h434

// Serial control register bit positions.
`define UAM_CTRL_MODE_HI       7
`define UAM_CTRL_MODE_LO       6
`define UAM_CTRL_MULTIPROC     5
`define UAM_CTRL_RX_ENABLE     4
`define UAM_CTRL_TX_NINTH      3
`define UAM_CTRL_RX_NINTH      2
`define UAM_CTRL_TX_DONE       1
`define UAM_CTRL_RX_DONE       0

// Reset values.
`define UAM_CTRL_RESET         8'h00
`define UAM_SLAVE_ADDR_RESET   8'h00
`define UAM_SLAVE_MASK_RESET   8'h00
`define UAM_RX_DATA_RESET      8'h00
`define UAM_IRQ_RESET          5'h00
`define UAM_INFO_RESET         3'h0

// Serial modes.
`define UAM_MODE0              2'h0
`define UAM_MODE1              2'h1
`define UAM_MODE2              2'h2
`define UAM_MODE3              2'h3

// Interrupt status and mask bit positions.
`define UAM_IRQ_W              5
`define UAM_IRQ_ACCEPT         0
`define UAM_IRQ_ADDR_HIT       1
`define UAM_IRQ_ADDR_MISS      2
`define UAM_IRQ_DATA_DROP      3
`define UAM_IRQ_OVERRUN        4

// Match information register bit positions.
`define UAM_INFO_W             3
`define UAM_INFO_GIVEN         0
`define UAM_INFO_BROADCAST     1
`define UAM_INFO_NINTH         2

`endif

/* rtl/uam_pkg.sv */
`include "uam_defines.svh"

package uam_pkg;

    // One write or read request on the register port.
    typedef struct packed {
        logic [`UAM_ADDR_W-1:0] addr;
        logic [`UAM_DATA_W-1:0] wrData;
        logic                   wrStrobe;
        logic                   rdStrobe;
    } uam_reg_req_type;

    // One frame handed over by the receive shifter.
    typedef struct packed {
        logic [`UAM_DATA_W-1:0] data;
        logic                   ninth;
        logic                   stopOk;
    } uam_rx_frame_type;

endpackage : uam_pkg

/* rtl/uam_addr_match.sv */
`timescale 1ns/1ps

module uam_addr_match #(
    parameter int WIDTH = 8
) (
    // Received address byte.
    input  wire logic [WIDTH-1:0] rxByte,
    // Programmed address and mask.
    input  wire logic [WIDTH-1:0] slaveAddr,
    input  wire logic [WIDTH-1:0] slaveMask,
    // Comparison results.
    output logic                  givenHit,
    output logic                  broadcastHit
);

    logic [WIDTH-1:0] givenBit;
    logic [WIDTH-1:0] broadcastBit;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            assign givenBit[i]     = ~slaveMask[i] | (rxByte[i] == slaveAddr[i]);
            assign broadcastBit[i] = ~(slaveAddr[i] | slaveMask[i]) | rxByte[i];
        end
    endgenerate

    assign givenHit     = &givenBit;
    assign broadcastHit = &broadcastBit;

endmodule : uam_addr_match

/* dv/uam_auto_address_match_monitor.sv */
`timescale 1ns/1ps
`include "uam_defines.svh"

module uam_auto_address_match_monitor (
    // Clock, reset and enable.
    input wire logic                      clk,
    input wire logic                      rst_b,
    input wire logic                      ce,
    // Register port.
    input wire uam_pkg::uam_reg_req_type  regReq,
    input wire logic [`UAM_DATA_W-1:0]    rdData,
    // Receive side.
    input wire uam_pkg::uam_rx_frame_type rxFrame,
    input wire logic                      rxComplete,
    input wire logic [1:0]                serialMode,
    input wire logic                      receiveEnable,
    input wire logic                      rxDoneFlag,
    input wire logic                      rxNinthBit,
    input wire logic                      frameAccepted
);
    logic       mpReg;
    logic [7:0] addrReg;
    logic [7:0] maskReg;
    logic       rxc;
    logic       filt;
    logic       givenOk;
    logic       bcastOk;

    // Shadows of the programmed values, since they have no port of their own.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mpReg   <= 1'b0;
            addrReg <= 8'h00;
            maskReg <= 8'h00;
        end else if (ce && regReq.wrStrobe) begin
            case (regReq.addr)
                `UAM_OFS_SERIAL_CTRL: mpReg <= regReq.wrData[`UAM_CTRL_MULTIPROC];
                `UAM_OFS_SLAVE_ADDR:  addrReg <= regReq.wrData;
                `UAM_OFS_SLAVE_MASK:  maskReg <= regReq.wrData;
                default: ;
            endcase
        end
    end

    assign rxc     = rxComplete && ce;
    assign filt    = mpReg && serialMode[1];
    assign givenOk = ((rxFrame.data ^ addrReg) & maskReg) == 8'h00;
    assign bcastOk = (rxFrame.data & (addrReg | maskReg)) == (addrReg | maskReg);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_data_drop: assert property (
        rxc && filt && !rxFrame.ninth |=> !frameAccepted) else $error("data frame accepted");
    a_given_accept: assert property (
        rxc && filt && receiveEnable && rxFrame.ninth && givenOk |=> frameAccepted && rxDoneFlag)
        else $error("given address not accepted");
    a_bcast_accept: assert property (
        rxc && filt && receiveEnable && rxFrame.ninth && bcastOk |=> frameAccepted && rxDoneFlag)
        else $error("broadcast address not accepted");
    a_miss_refuse: assert property (
        rxc && filt && rxFrame.ninth && !givenOk && !bcastOk |=> !frameAccepted)
        else $error("non-matching address accepted");
    a_open_accept: assert property (
        rxc && receiveEnable && (!mpReg || serialMode == `UAM_MODE0) |=> frameAccepted)
        else $error("unfiltered frame not accepted");
    a_stop_refuse: assert property (
        rxc && mpReg && serialMode == `UAM_MODE1 && !rxFrame.stopOk |=> !frameAccepted)
        else $error("frame without stop bit accepted");
    a_ninth_store: assert property (
        rxc && serialMode[1] |=> rxNinthBit == $past(rxFrame.ninth))
        else $error("ninth bit not stored");
    a_accept_cause: assert property (frameAccepted && $past(ce) |-> $past(rxc))
        else $error("accept without frame");
    a_done_holds: assert property (rxDoneFlag && !(ce && regReq.wrStrobe
        && regReq.addr == `UAM_OFS_SERIAL_CTRL) |=> rxDoneFlag) else $error("done flag dropped");
    a_read_idle: assert property (!$past(regReq.rdStrobe) && $past(ce) |-> rdData == 8'h00)
        else $error("read data outside read slot");

    c_given: cover property (rxc && filt && rxFrame.ninth && givenOk);
    c_drop: cover property (rxc && filt && !rxFrame.ninth);
    c_open: cover property (rxc && serialMode == `UAM_MODE0 && mpReg);
endmodule : uam_auto_address_match_monitor

bind uam_auto_address_match uam_auto_address_match_monitor i_mon (.clk(clk), .rst_b(rst_b),
    .ce(ce), .regReq(regReq), .rdData(rdData), .rxFrame(rxFrame), .rxComplete(rxComplete),
    .serialMode(serialMode), .receiveEnable(receiveEnable), .rxDoneFlag(rxDoneFlag),
    .rxNinthBit(rxNinthBit), .frameAccepted(frameAccepted));

/* dv/uam_master_model.sv */
`timescale 1ns/1ps

module uam_master_model (
    // Clock.
    input  wire logic                 clk,
    // Frame towards the receiver.
    output uam_pkg::uam_rx_frame_type rxFrame,
    output logic                      rxComplete
);
    initial begin
        rxFrame    = '0;
        rxComplete = 1'b0;
    end

    task automatic send(input logic [7:0] data, input logic isAddr, input logic stopOk);
        @(posedge clk);
        rxFrame    <= {data, isAddr, stopOk};
        rxComplete <= 1'b1;
        @(posedge clk);
        rxComplete <= 1'b0;
        // Stale frame bits are inverted so a late sample can never look right.
        rxFrame    <= ~rxFrame;
    endtask : send
endmodule : uam_master_model

/* dv/uam_auto_address_match_test.sv */
`timescale 1ns/1ps
`include "uam_defines.svh"
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errorCnt++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module uam_auto_address_match_test;
    logic                      clk;
    logic                      rst_b;
    logic                      ce;
    uam_pkg::uam_reg_req_type  regReq;
    logic [7:0]                rdData;
    uam_pkg::uam_rx_frame_type rxFrame;
    logic                      rxComplete;
    logic [1:0]                serialMode;
    logic                      receiveEnable;
    logic                      txNinthBit;
    logic                      txDoneFlag;
    logic                      rxDoneFlag;
    logic                      rxNinthBit;
    logic                      frameAccepted;
    logic                      irq;
    int                        errorCnt;
    int                        numChecks;
    int                        cycles;
    logic [7:0]                cData [5] = '{8'hc2, 8'hc0, 8'hc1, 8'hfd, 8'hc0};
    logic                      cNinth [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic                      cAcc [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    uam_auto_address_match i_uam_auto_address_match (.clk(clk), .rst_b(rst_b), .ce(ce),
        .regReq(regReq), .rdData(rdData), .rxFrame(rxFrame), .rxComplete(rxComplete),
        .serialMode(serialMode), .receiveEnable(receiveEnable), .txNinthBit(txNinthBit),
        .txDoneFlag(txDoneFlag), .rxDoneFlag(rxDoneFlag), .rxNinthBit(rxNinthBit),
        .frameAccepted(frameAccepted), .irq(irq));
    uam_master_model i_uam_master_model (.clk(clk), .rxFrame(rxFrame), .rxComplete(rxComplete));

    task automatic report_and_stop();
        if (errorCnt == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        regReq.wrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        regReq <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        regReq.rdStrobe <= 1'b0;
        #1;
        `CHK(rdData, e)
    endtask : rd

    // Registered outputs are given two more edges after the taking edge to settle.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic frame(input logic [7:0] d, input logic n, input logic s);
        i_uam_master_model.send(d, n, s);
        settle();
    endtask : frame

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            errorCnt++;
            report_and_stop();
        end
    end

    initial begin
        regReq = '0;
        rst_b  = 1'b0;
        ce     = 1'b1;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(`UAM_OFS_SERIAL_CTRL, 8'h00);
        rd(`UAM_OFS_SLAVE_ADDR, 8'h00);
        rd(`UAM_OFS_SLAVE_MASK, 8'h00);
        rd(12'h4ff, 8'h00);
        wr(`UAM_OFS_SERIAL_CTRL, 8'h0a);
        settle();
        `CHK(({serialMode, receiveEnable, txNinthBit, txDoneFlag}), 5'h03)
        wr(`UAM_OFS_SERIAL_CTRL, 8'hf0);
        frame(8'h5a, 1'b1, 1'b1);
        `CHK(({serialMode, receiveEnable, txNinthBit, txDoneFlag}), 5'h1c)
        rd(`UAM_OFS_SERIAL_CTRL, 8'hf5);
        rd(`UAM_OFS_RX_DATA, 8'h5a);
        wr(`UAM_OFS_SLAVE_ADDR, 8'hc0);
        wr(`UAM_OFS_SLAVE_MASK, 8'hfd);
        rd(`UAM_OFS_SLAVE_ADDR, 8'hc0);
        rd(`UAM_OFS_SLAVE_MASK, 8'hfd);
        for (int i = 0; i < 5; i++) begin
            wr(`UAM_OFS_SERIAL_CTRL, 8'hb0);
            frame(cData[i], cNinth[i], 1'b1);
            rd(`UAM_OFS_SERIAL_CTRL, 8'hb0 | {5'h00, cNinth[i], 1'b0, cAcc[i]});
        end
        wr(`UAM_OFS_IRQ_MASK, 8'h04);
        settle();
        `CHK(irq, 1'b1)
        wr(`UAM_OFS_IRQ_MASK, 8'h00);
        settle();
        `CHK(irq, 1'b0)
        wr(`UAM_OFS_IRQ_MASK, 8'h04);
        settle();
        `CHK(irq, 1'b1)
        wr(`UAM_OFS_IRQ_STATUS, 8'h04);
        settle();
        `CHK(irq, 1'b0)
        rd(`UAM_OFS_IRQ_STATUS, 8'h0b);
        wr(`UAM_OFS_SERIAL_CTRL, 8'h30);
        frame(8'h11, 1'b0, 1'b1);
        `CHK(rxDoneFlag, 1'b1)
        wr(`UAM_OFS_SERIAL_CTRL, 8'h90);
        frame(8'h22, 1'b0, 1'b1);
        `CHK(rxDoneFlag, 1'b1)
        rd(`UAM_OFS_RX_DATA, 8'h22);
        // A set enable bit in mode 1 refuses a frame with a bad stop bit.
        wr(`UAM_OFS_SERIAL_CTRL, 8'h70);
        frame(8'h44, 1'b0, 1'b0);
        `CHK(rxDoneFlag, 1'b0)
        frame(8'h55, 1'b0, 1'b1);
        `CHK(rxDoneFlag, 1'b1)
        // A low clock enable must leave a completed frame untaken.
        wr(`UAM_OFS_SERIAL_CTRL, 8'h90);
        ce <= 1'b0;
        frame(8'h33, 1'b1, 1'b1);
        `CHK(rxDoneFlag, 1'b0)
        ce <= 1'b1;
        rd(`UAM_OFS_RX_DATA, 8'h55);
        // A second reset in mid-run must clear the programmed values.
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(`UAM_OFS_SLAVE_ADDR, 8'h00);
        rd(`UAM_OFS_SLAVE_MASK, 8'h00);
        rd(`UAM_OFS_SERIAL_CTRL, 8'h00);
        report_and_stop();
    end
endmodule : uam_auto_address_match_test
